// File: hw/wlcs_limit_cmp.sv
// Limit comparators: one registered trip pulse per fresh measurement
`timescale 1ns/100ps

module wlcs_limit_cmp
    import wlcs_pkg::*;
(
    input  wire logic       mclk,     // 10 MHz clock
    input  wire logic       rst,      // Synchronous reset
    input  wire logic       ce,       // Clock enable
    input  wire wlcs_meas_s meas,     // Measurements with valids
    input  wire wlcs_lim_s  lim,      // Stored limits
    output logic [3:0]      trip_r    // One-cycle trip pulses
);

    // ========================================================================
    // Magnitude of the signed current
    // ========================================================================
    // Seventeen bits so that the most negative code still compares right
    wire logic [16:0] cur_mag = meas.cur[15]
        ? (17'h1FFFF ^ {1'b1, meas.cur}) + 17'h00001
        : {1'b0, meas.cur};

    // ========================================================================
    // Comparisons, gated by the valid of the matching reading
    // ========================================================================
    wire logic oc_hit = meas.cur_vld
        & (cur_mag > {1'b0, lim.oc});
    wire logic ov_hit = meas.vbus_vld & (meas.vbus > lim.ov);
    wire logic uv_hit = meas.vbus_vld & (meas.vbus < lim.uv);
    wire logic op_hit = meas.pwr_vld & (meas.pwr > lim.op);
    wire logic [3:0] trip_nxt = {op_hit, uv_hit, ov_hit, oc_hit};

    // Trip pulses last one cycle; evaluated only on new results
    always_ff @(posedge mclk)
    begin
        if (rst)
            trip_r <= 4'h0;
        else if (ce)
            trip_r <= trip_nxt;
    end

endmodule

// File: hw/wlcs_pkg.sv
// Package: command codes, field layouts and reset values of the limit bank
package wlcs_pkg;

    // ========================================================================
    // Command codes seen on the register port
    // ========================================================================
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_CAPABILITY   = 8'h19;
    localparam logic [7:0] CMD_OC_LIMIT     = 8'h4A;
    localparam logic [7:0] CMD_OV_LIMIT     = 8'h57;
    localparam logic [7:0] CMD_UV_LIMIT     = 8'h58;
    localparam logic [7:0] CMD_OP_LIMIT     = 8'h6B;
    localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
    localparam logic [7:0] CMD_STATUS_OUT   = 8'h7B;
    localparam logic [7:0] CMD_STATUS_IN    = 8'h7C;
    localparam logic [7:0] CMD_ALERT_MASK   = 8'hD2;

    // ========================================================================
    // Constant values, reset values and writable-field masks
    // ========================================================================
    localparam logic [7:0]  CAPABILITY_VAL = 8'hB0;
    localparam logic [15:0] RST_OC_LIMIT   = 16'h7FF8;
    localparam logic [15:0] RST_OV_LIMIT   = 16'h7FF8;
    localparam logic [15:0] RST_UV_LIMIT   = 16'h0000;
    localparam logic [15:0] RST_OP_LIMIT   = 16'hFFF0;
    localparam logic [7:0]  RST_ALERT_MASK = 8'hF0;
    localparam logic [15:0] FLD_MID_LIMIT  = 16'h7FF8;  // Field in 14:3
    localparam logic [15:0] FLD_TOP_LIMIT  = 16'hFFF0;  // Field in 15:4

    // ========================================================================
    // Bit positions in the status and mask registers
    // ========================================================================
    localparam int SB_OTHER = 0;   // Status byte summary bit
    localparam int SW_OUT   = 14;  // Status word output bit
    localparam int SW_IN    = 13;  // Status word input bit
    localparam int SO_OC    = 5;   // Output status overcurrent
    localparam int SI_OV    = 6;   // Input status overvoltage
    localparam int SI_UV    = 5;   // Input status undervoltage
    localparam int SI_OC    = 1;   // Input status overcurrent
    localparam int SI_OP    = 0;   // Input status overpower

    // Index of each limit trip, and of each latched flag
    localparam int TRIP_OC = 0;
    localparam int TRIP_OV = 1;
    localparam int TRIP_UV = 2;
    localparam int TRIP_OP = 3;
    localparam int FLG_OUT_OC = 0;
    localparam int FLG_IN_OC  = 1;
    localparam int FLG_OV     = 2;
    localparam int FLG_UV     = 3;
    localparam int FLG_OP     = 4;
    localparam int NUM_FLAGS  = 5;

    // ========================================================================
    // Carriers
    // ========================================================================
    typedef struct packed {
        logic        cur_vld;   // New current reading
        logic [15:0] cur;       // Signed current reading
        logic        vbus_vld;  // New bus voltage reading
        logic [15:0] vbus;      // Bus voltage reading
        logic        pwr_vld;   // New power value
        logic [15:0] pwr;       // Power value
    } wlcs_meas_s;

    typedef struct packed {
        logic        vld;       // Command strobe
        logic        wr;        // 1 write, 0 read
        logic [7:0]  code;      // Command code
        logic [15:0] wdata;     // Write data
    } wlcs_cmd_s;

    typedef struct packed {
        logic [15:0] oc;
        logic [15:0] ov;
        logic [15:0] uv;
        logic [15:0] op;
    } wlcs_lim_s;

endpackage

// File: hw/wlcs_top.sv
// Warning limit bank: limits, compare, latched status flags and alert pin
`timescale 1ns/100ps

module wlcs_top
    import wlcs_pkg::*;
(
    input  wire logic       mclk,        // 10 MHz clock
    input  wire logic       rst,         // Synchronous reset, high
    input  wire logic       ce,          // Clock enable, freezes all
    input  wire wlcs_cmd_s  cmd,         // Command from protocol engine
    input  wire wlcs_meas_s meas,        // Fresh measurements
    output logic [15:0]     rd_data_r,   // Read answer
    output logic            rd_vld_r,    // Read answer strobe
    output logic            cmd_bad_r,   // Unsupported command pulse
    output logic            alert_o_r,   // Alert pin output level
    output logic            alert_oe_r   // Alert pin pulls low when high
);

    // ========================================================================
    // Command decode
    // ========================================================================
    function automatic logic hit(input wlcs_cmd_s c, input logic [7:0] code,
                                 input logic wr);
        hit = c.vld & (c.wr == wr) & (c.code == code);
    endfunction

    wire logic wr_oc   = hit(cmd, CMD_OC_LIMIT, 1'b1);
    wire logic wr_ov   = hit(cmd, CMD_OV_LIMIT, 1'b1);
    wire logic wr_uv   = hit(cmd, CMD_UV_LIMIT, 1'b1);
    wire logic wr_op   = hit(cmd, CMD_OP_LIMIT, 1'b1);
    wire logic wr_mask = hit(cmd, CMD_ALERT_MASK, 1'b1);
    wire logic wr_sout = hit(cmd, CMD_STATUS_OUT, 1'b1);
    wire logic wr_sin  = hit(cmd, CMD_STATUS_IN, 1'b1);
    wire logic clr_all = hit(cmd, CMD_CLEAR_FAULTS, 1'b1);
    wire logic rd_req  = cmd.vld & ~cmd.wr;

    // ========================================================================
    // Limit and mask registers
    // ========================================================================
    logic [15:0] oc_lim_r;
    logic [15:0] ov_lim_r;
    logic [15:0] uv_lim_r;
    logic [15:0] op_lim_r;
    logic [7:0]  mask_r;
    wlcs_lim_s   lim;

    // Reserved bits are dropped at the write, so they always read zero
    wire logic [15:0] oc_lim_nxt = wr_oc ? (cmd.wdata & FLD_MID_LIMIT)
                                         : oc_lim_r;
    wire logic [15:0] ov_lim_nxt = wr_ov ? (cmd.wdata & FLD_MID_LIMIT)
                                         : ov_lim_r;
    wire logic [15:0] uv_lim_nxt = wr_uv ? (cmd.wdata & FLD_MID_LIMIT)
                                         : uv_lim_r;
    wire logic [15:0] op_lim_nxt = wr_op ? (cmd.wdata & FLD_TOP_LIMIT)
                                         : op_lim_r;
    wire logic [7:0]  mask_nxt   = wr_mask ? cmd.wdata[7:0] : mask_r;

    // Limit words update on a word write of their own code
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            oc_lim_r <= RST_OC_LIMIT;
            ov_lim_r <= RST_OV_LIMIT;
            uv_lim_r <= RST_UV_LIMIT;
            op_lim_r <= RST_OP_LIMIT;
            mask_r   <= RST_ALERT_MASK;
        end
        else if (ce)
        begin
            oc_lim_r <= oc_lim_nxt;
            ov_lim_r <= ov_lim_nxt;
            uv_lim_r <= uv_lim_nxt;
            op_lim_r <= op_lim_nxt;
            mask_r   <= mask_nxt;
        end
    end

    assign lim = '{oc: oc_lim_r, ov: ov_lim_r, uv: uv_lim_r, op: op_lim_r};

    // ========================================================================
    // Comparators
    // ========================================================================
    logic [3:0] trip;

    wlcs_limit_cmp u_cmp
    (
        .mclk   (mclk),
        .rst    (rst),
        .ce     (ce),
        .meas   (meas),
        .lim    (lim),
        .trip_r (trip)
    );

    // ========================================================================
    // Latched warning flags
    // ========================================================================
    logic [NUM_FLAGS-1:0] flag_r;
    logic [NUM_FLAGS-1:0] flag_set;
    logic [NUM_FLAGS-1:0] flag_w1c;
    logic [NUM_FLAGS-1:0] flag_mask;
    logic [NUM_FLAGS-1:0] flag_nxt;

    // One overcurrent trip lands in both the output and input flags
    assign flag_set[FLG_OUT_OC] = trip[TRIP_OC];
    assign flag_set[FLG_IN_OC]  = trip[TRIP_OC];
    assign flag_set[FLG_OV]     = trip[TRIP_OV];
    assign flag_set[FLG_UV]     = trip[TRIP_UV];
    assign flag_set[FLG_OP]     = trip[TRIP_OP];

    // Write-one-to-clear, bit positions as the status registers show them
    assign flag_w1c[FLG_OUT_OC] = wr_sout & cmd.wdata[SO_OC];
    assign flag_w1c[FLG_IN_OC]  = wr_sin & cmd.wdata[SI_OC];
    assign flag_w1c[FLG_OV]     = wr_sin & cmd.wdata[SI_OV];
    assign flag_w1c[FLG_UV]     = wr_sin & cmd.wdata[SI_UV];
    assign flag_w1c[FLG_OP]     = wr_sin & cmd.wdata[SI_OP];

    // Both overcurrent flags share the one overcurrent mask bit
    assign flag_mask[FLG_OUT_OC] = mask_r[SI_OC];
    assign flag_mask[FLG_IN_OC]  = mask_r[SI_OC];
    assign flag_mask[FLG_OV]     = mask_r[SI_OV];
    assign flag_mask[FLG_UV]     = mask_r[SI_UV];
    assign flag_mask[FLG_OP]     = mask_r[SI_OP];

    // A trip in the same cycle as a clear wins, so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++)
        begin : g_flag
            assign flag_nxt[gi] = flag_set[gi]
                | (flag_r[gi] & ~(clr_all | flag_w1c[gi]));
        end
    endgenerate

    // Flags hold until the host clears them
    always_ff @(posedge mclk)
    begin
        if (rst)
            flag_r <= '0;
        else if (ce)
            flag_r <= flag_nxt;
    end

    // ========================================================================
    // Status views built from the flags
    // ========================================================================
    wire logic other_warning_summary = flag_r[FLG_OUT_OC] | flag_r[FLG_IN_OC]
        | flag_r[FLG_OV] | flag_r[FLG_UV];
    wire logic out_any = flag_r[FLG_OUT_OC];
    wire logic in_any  = flag_r[FLG_IN_OC] | flag_r[FLG_OV]
        | flag_r[FLG_UV] | flag_r[FLG_OP];

    logic [7:0]  status_byte;
    logic [15:0] status_word;
    logic [7:0]  output_side_status;
    logic [7:0]  input_side_status;

    always_comb
    begin
        status_byte               = 8'h00;
        status_byte[SB_OTHER]     = other_warning_summary;
        status_word               = {8'h00, status_byte};
        status_word[SW_OUT]       = out_any;
        status_word[SW_IN]        = in_any;
        output_side_status        = 8'h00;
        output_side_status[SO_OC] = flag_r[FLG_OUT_OC];
        input_side_status         = 8'h00;
        input_side_status[SI_OV]  = flag_r[FLG_OV];
        input_side_status[SI_UV]  = flag_r[FLG_UV];
        input_side_status[SI_OC]  = flag_r[FLG_IN_OC];
        input_side_status[SI_OP]  = flag_r[FLG_OP];
    end

    // ========================================================================
    // Read mux
    // ========================================================================
    logic [15:0] rd_mux;
    logic        known;

    // Byte-wide registers sit in the low byte, high byte zero
    always_comb
    begin
        known  = 1'b1;
        rd_mux = 16'h0000;
        unique case (cmd.code)
            CMD_CAPABILITY:  rd_mux = {8'h00, CAPABILITY_VAL};
            CMD_OC_LIMIT:    rd_mux = oc_lim_r;
            CMD_OV_LIMIT:    rd_mux = ov_lim_r;
            CMD_UV_LIMIT:    rd_mux = uv_lim_r;
            CMD_OP_LIMIT:    rd_mux = op_lim_r;
            CMD_STATUS_BYTE: rd_mux = {8'h00, status_byte};
            CMD_STATUS_WORD: rd_mux = status_word;
            CMD_STATUS_OUT:  rd_mux = {8'h00, output_side_status};
            CMD_STATUS_IN:   rd_mux = {8'h00, input_side_status};
            CMD_ALERT_MASK:  rd_mux = {8'h00, mask_r};
            default:         known  = 1'b0;
        endcase
    end

    wire logic wr_known = wr_oc | wr_ov | wr_uv | wr_op | wr_mask
        | wr_sout | wr_sin | clr_all;
    wire logic bad_nxt = cmd.vld & (cmd.wr ? ~wr_known : ~known);

    // Answer one cycle after the request; unknown codes read zero
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rd_data_r <= 16'h0000;
            rd_vld_r  <= 1'b0;
            cmd_bad_r <= 1'b0;
        end
        else if (ce)
        begin
            rd_data_r <= rd_req ? rd_mux : rd_data_r;
            rd_vld_r  <= rd_req;
            cmd_bad_r <= bad_nxt;
        end
    end

    // ========================================================================
    // Alert pin
    // ========================================================================
    // Masked flags still latch; they just do not pull the pin
    wire logic alert_nxt = |(flag_nxt & ~flag_mask);

    // Open-drain: output level is always low, only the enable moves
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            alert_oe_r <= 1'b0;
            alert_o_r  <= 1'b0;
        end
        else if (ce)
        begin
            alert_oe_r <= alert_nxt;
            alert_o_r  <= 1'b0;
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    // One clock domain, so every check shares the clock, and all but chk_reset_lim the reset guard
    default clocking chk_cb @(posedge mclk);
    endclocking

    default disable iff (rst);

    sequence s_cap_read;
        ce && rd_req && cmd.code == CMD_CAPABILITY;
    endsequence

    sequence s_oc_trip;
        ce && trip[TRIP_OC];
    endsequence

    sequence s_clear_quiet;
        ce && clr_all && trip == 4'h0;
    endsequence

    chk_cap_value: assert property (s_cap_read |=>
        rd_vld_r && rd_data_r == 16'h00B0)
        else $error("capability read wrong");

    chk_oc_flags: assert property (s_oc_trip |=>
        flag_r[FLG_OUT_OC] && flag_r[FLG_IN_OC]
        && status_word[SW_OUT] && status_word[SW_IN]
        && status_byte[SB_OTHER])
        else $error("overcurrent flags not set");

    chk_neg_current: assert property (ce && meas.cur_vld
        && meas.cur == 16'h8000 |=> trip[TRIP_OC])
        else $error("negative current not tripped");

    chk_oc_resv: assert property (oc_lim_r[15] == 1'b0
        && oc_lim_r[2:0] == 3'h0 && op_lim_r[3:0] == 4'h0)
        else $error("reserved limit bits set");

    chk_mid_resv: assert property (ov_lim_r[15] == 1'b0
        && ov_lim_r[2:0] == 3'h0
        && uv_lim_r[15] == 1'b0 && uv_lim_r[2:0] == 3'h0)
        else $error("reserved voltage limit bits set");

    // Reset acts whatever the enable does, so this one is never guarded
    chk_reset_lim: assert property (disable iff (1'b0) rst |=>
        oc_lim_r == 16'h7FF8 && ov_lim_r == 16'h7FF8
        && uv_lim_r == 16'h0000 && op_lim_r == 16'hFFF0)
        else $error("limit reset value wrong");

    chk_uv_trip: assert property (ce && meas.vbus_vld
        && meas.vbus < uv_lim_r && !wr_uv
        |=> (trip[TRIP_UV] and (ce |=> input_side_status[SI_UV])))
        else $error("undervoltage not flagged");

    chk_clear_all: assert property (s_clear_quiet |=>
        flag_r == '0 && !alert_oe_r)
        else $error("clear faults left a flag");

    chk_mask_quiet: assert property (ce && mask_r == 8'hFF
        && !wr_mask [*2] |=> !alert_oe_r)
        else $error("masked warning drove alert");

    chk_summary_or: assert property (status_byte[SB_OTHER] ==
        (output_side_status[SO_OC] | input_side_status[SI_OC]
        | input_side_status[SI_OV] | input_side_status[SI_UV]))
        else $error("summary bit mismatch");

    chk_flag_hold: assert property (ce && flag_r[FLG_OP]
        && !clr_all && !wr_sin |=> flag_r[FLG_OP])
        else $error("flag dropped without clear");

    chk_op_alert: assert property (ce && flag_r[FLG_OP]
        && !mask_r[SI_OP] && !clr_all && !wr_sin |=> alert_oe_r)
        else $error("unmasked overpower left alert quiet");

endmodule

// File: tb/wlcs_host_model.sv
// Host-side model that issues register commands to the limit bank
`timescale 1ns/100ps

module wlcs_host_model
    import wlcs_pkg::*;
(
    input  wire logic        mclk,     // Bench clock
    input  wire logic [15:0] rd_data,  // Read answer
    input  wire logic        rd_vld,   // Read answer strobe
    output wlcs_cmd_s        cmd       // Command to the bank
);
    // ========================================================================
    // Command tasks
    // ========================================================================
    // Idle bus carries no command
    initial
    begin
        cmd = '0;
    end

    // One-cycle strobe launched just after an edge; when idle the data
    // lines show the inverse so a stale word is never mistaken for fresh
    task automatic send(input logic wr_i, input logic [7:0] code,
                        input logic [15:0] data);
        @(posedge mclk);
        #10;
        cmd = {1'b1, wr_i, code, data};
        @(posedge mclk);
        #10;
        cmd.vld = 1'b0;
        cmd.wdata = ~data;
    endtask

    // Limits go in with the reading's own scaling, so raw words
    task automatic write(input logic [7:0] code, input logic [15:0] d);
        send(1'b1, code, d);
    endtask

    // Send-byte clear of every latched flag
    task automatic clear_faults();
        send(1'b1, CMD_CLEAR_FAULTS, 16'h0000);
    endtask

    // Answer is taken one edge after the request, as it stands then
    task automatic read(input logic [7:0] code, output logic [16:0] ans);
        send(1'b0, code, 16'h0000);
        ans = {rd_vld, rd_data};
    endtask
endmodule

// File: tb/wlcs_top_test.sv
// Self-checking bench for the warning limit bank
`timescale 1ns/100ps

module wlcs_top_test;
    import wlcs_pkg::*;

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    wlcs_cmd_s   cmd;
    wlcs_meas_s  meas = '0;
    logic [15:0] rd_data;
    logic        rd_vld;
    logic        alert_oe;
    logic        alert_o;
    logic        cmd_bad;
    int          err_count = 0;
    int          samples_checked = 0;

    // ========================================================================
    // Clock, design and host
    // ========================================================================
    always #50 mclk = ~mclk;

    wlcs_top dut (.mclk(mclk), .rst(rst), .ce(ce), .cmd(cmd), .meas(meas),
        .rd_data_r(rd_data), .rd_vld_r(rd_vld), .cmd_bad_r(cmd_bad),
        .alert_o_r(alert_o), .alert_oe_r(alert_oe));

    wlcs_host_model host (.mclk(mclk), .rd_data(rd_data),
        .rd_vld(rd_vld), .cmd(cmd));

    // ========================================================================
    // Helpers
    // ========================================================================
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Read must answer with the strobe and the expected word
    task automatic rd(input logic [7:0] code, input logic [15:0] exp);
        logic [16:0] a;
        host.read(code, a);
        chk(a, {1'b1, exp});
    endtask

    // Fresh reading on the selected valids; readings scrambled after
    task automatic measure(input logic [2:0] v, input logic [15:0] x);
        @(posedge mclk);
        #10;
        meas = {v[2], x, v[1], x, v[0], x};
        @(posedge mclk);
        #10;
        meas = {1'b0, ~x, 1'b0, ~x, 1'b0, ~x};
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_reset();
        rd(CMD_OC_LIMIT, 16'h7FF8);
        rd(CMD_OV_LIMIT, 16'h7FF8);
        rd(CMD_UV_LIMIT, 16'h0000);
        rd(CMD_OP_LIMIT, 16'hFFF0);
        rd(CMD_CAPABILITY, 16'h00B0);
    endtask

    // Reserved bits are dropped even when written as ones
    task automatic t_fields();
        host.write(CMD_OC_LIMIT, 16'hFFFF);
        host.write(CMD_OV_LIMIT, 16'hFFFF);
        host.write(CMD_UV_LIMIT, 16'hFFFF);
        host.write(CMD_OP_LIMIT, 16'hFFFF);
        rd(CMD_OC_LIMIT, 16'h7FF8);
        rd(CMD_OV_LIMIT, 16'h7FF8);
        rd(CMD_UV_LIMIT, 16'h7FF8);
        rd(CMD_OP_LIMIT, 16'hFFF0);
    endtask

    // Negative current at the limit must not trip, one step past must
    task automatic t_overcurrent();
        host.write(CMD_ALERT_MASK, 16'h0000);
        host.write(CMD_OC_LIMIT, 16'h0100);
        measure(3'b100, 16'hFF00);
        rd(CMD_STATUS_IN, 16'h0000);
        measure(3'b100, 16'hFEF8);
        rd(CMD_STATUS_BYTE, 16'h0001);
        rd(CMD_STATUS_WORD, 16'h6001);
        rd(CMD_STATUS_OUT, 16'h0020);
        rd(CMD_STATUS_IN, 16'h0002);
        chk({15'h0, alert_o, alert_oe}, 17'h1);
        host.clear_faults();
        #1;
        chk({15'h0, alert_o, alert_oe}, 17'h0);
        rd(CMD_STATUS_IN, 16'h0000);
        // Most negative code has no positive twin in sixteen bits
        measure(3'b100, 16'h8000);
        rd(CMD_STATUS_IN, 16'h0002);
        host.clear_faults();
    endtask

    // Voltage warnings are masked by default yet still latch
    task automatic t_voltage();
        host.write(CMD_ALERT_MASK, 16'h00F0);
        host.write(CMD_OV_LIMIT, 16'h1000);
        host.write(CMD_UV_LIMIT, 16'h0800);
        measure(3'b010, 16'h1008);
        rd(CMD_STATUS_IN, 16'h0040);
        rd(CMD_STATUS_WORD, 16'h2001);
        chk({16'h0, alert_oe}, 17'h0);
        host.write(CMD_STATUS_IN, 16'h0040);
        rd(CMD_STATUS_BYTE, 16'h0000);
        measure(3'b010, 16'h07F8);
        rd(CMD_STATUS_IN, 16'h0020);
        rd(CMD_STATUS_BYTE, 16'h0001);
        host.clear_faults();
    endtask

    // Overpower lifts the input bit and alert but not the summary
    task automatic t_overpower();
        host.write(CMD_OP_LIMIT, 16'h1000);
        measure(3'b001, 16'h1010);
        rd(CMD_STATUS_IN, 16'h0001);
        rd(CMD_STATUS_WORD, 16'h2000);
        rd(CMD_STATUS_BYTE, 16'h0000);
        chk({16'h0, alert_oe}, 17'h1);
        host.clear_faults();
        // Fully masked: the flag still latches, the pin stays released
        host.write(CMD_ALERT_MASK, 16'h00FF);
        measure(3'b001, 16'h1010);
        rd(CMD_STATUS_IN, 16'h0001);
        chk({15'h0, alert_o, alert_oe}, 17'h0);
        host.clear_faults();
    endtask

    // Read-only code refuses a write; a command under ce low is lost
    task automatic t_badcmd();
        host.write(CMD_CAPABILITY, 16'h00FF);
        chk({16'h0, cmd_bad}, 17'h1);
        rd(CMD_CAPABILITY, 16'h00B0);
        chk({16'h0, cmd_bad}, 17'h0);
        ce = 1'b0;
        host.write(CMD_OC_LIMIT, 16'h0008);
        ce = 1'b1;
        rd(CMD_OC_LIMIT, 16'h0100);
    endtask

    // ========================================================================
    // Main sequence and watchdog
    // ========================================================================
    initial
    begin
        repeat (12) @(posedge mclk);
        #10;
        rst = 1'b0;
        t_reset();
        t_fields();
        t_overcurrent();
        t_voltage();
        t_overpower();
        t_badcmd();
        complete_run();
    end

    // The run needs about 120 cycles; far more means a hang
    initial
    begin
        #500000;
        err_count++;
        complete_run();
    end
endmodule
